// ==== sac_regs.svh ====
// Constants of the strap and serial configuration loader
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

`define SAC_CLK_MHZ           50
// Serial EEPROM clock half period, least time in ns
`define SAC_EE_HALF_NS        500
`define SAC_EE_HALF_CYC       ((`SAC_EE_HALF_NS * `SAC_CLK_MHZ + 999) / 1000)
`define SAC_EE_DIV_W          5
`define SAC_EE_READ_CMD       8'h03
`define SAC_EE_WORDS          8'h04
`define SAC_EE_FRAME_BITS     6'h20
// Configuration space offset of the reference clock disable bits
`define SAC_REFCLK_CFG_OFFSET 8'h98
// Upper four SMBus address bits, value arbitrary
`define SAC_SMB_ADDR_HI       4'h5

`define SAC_UPS_CODE_P0       2'h0
`define SAC_UPS_CODE_P1       2'h1
`define SAC_UPS_CODE_P2       2'h3
`define SAC_PORT0             2'h0
`define SAC_PORT1             2'h1
`define SAC_PORT2             2'h2
`define SAC_MPS_256           3'h1
`define SAC_MPS_512           3'h2

// Positions in the synchronised input vector
`define SAC_SYNC_W            14
`define SAC_IN_PL             0
`define SAC_IN_UPS_LO         1
`define SAC_IN_UPS_HI         2
`define SAC_IN_CS             3
`define SAC_IN_EEPROM_SERIAL_IN           4
`define SAC_IN_SDA            5
`define SAC_IN_SCL            6
`define SAC_IN_REQ_LO         7
`define SAC_IN_REQ_HI         9
`define SAC_IN_ADR_LO         10
`define SAC_IN_ADR_HI         12
`define SAC_IN_RST            13
`define SAC_SYNC_RESET        14'h0000

`endif

// ==== sac_pkg.sv ====
// Types of the strap and serial configuration loader
`include "sac_regs.svh"
package sac_pkg;

  typedef enum logic [2:0] {
    INIT_HOLD,
    INIT_STRAP,
    INIT_EE_GAP,
    INIT_EE_SHIFT,
    INIT_DONE
  } sac_init_t;

  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_RX,
    I2C_RXACK,
    I2C_TX,
    I2C_TXACK
  } sac_i2c_t;

  typedef struct packed {
    logic [`SAC_SYNC_W-1:0]   s1;
    logic [`SAC_SYNC_W-1:0]   s2;
    logic [`SAC_SYNC_W-1:0]   s3;
    logic [`SAC_SYNC_W-1:0]   filt;
    sac_init_t                init;
    logic [1:0]               port;
    logic                     ups_err;
    logic                     pl;
    logic                     ee_en;
    logic                     ee_drv;
    logic [2:0]               smb_lo;
    logic [`SAC_EE_DIV_W-1:0] div;
    logic                     sck;
    logic                     cs_n;
    logic                     mosi;
    logic [5:0]               bcnt;
    logic [31:0]              sr;
    logic [7:0]               addr;
    logic [15:0]              word;
    logic [7:0]               word_addr;
    logic                     word_vld;
    sac_i2c_t                 i2c;
    logic [7:0]               ish;
    logic [3:0]               ibit;
    logic                     iaddr;
    logic                     irw;
    logic                     inack;
    logic                     sda_low;
    logic [7:0]               wdata;
    logic                     wvld;
    logic [2:0]               refclk_en;
  } sac_state_t;

endpackage

// ==== sac_config.sv ====
// Strap sampling, EEPROM loader, reference clock gating and SMBus slave
// Behaviour
// - Low clock request enables matching reference clock
// - Config bits at 98h disable reference clocks
// - Upstream strap 00/01/11 selects port 0/1/2
// - Payload strap high advertises 512B, else 256B
// - Chip select strap low bypasses EEPROM
// - Chip select driven low for each access
// - Shift data out, sample EEPROM returning data
// - Device provides four-wire EEPROM serial clock
// - Open-drain SMBus clock and data port
// - SMBus address low bits from three pins
// - System reset initialises state, then straps sampled
// - Payload and select pins become debug outputs
`timescale 1ns/1ns
`include "sac_regs.svh"
module sac_config (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        system_reset_n_i,
  input  wire logic [3:1]  refclk_request_n_i,
  input  wire logic [3:1]  refclk_disable_i,
  output logic      [3:1]  refclk_enable_o,
  input  wire logic [1:0]  upstream_port_select_i,
  output logic             upstream_port_select_o,
  output logic             upstream_port_select_oe_n_o,
  input  wire logic        large_payload_strap_i,
  output logic             large_payload_strap_o,
  output logic             large_payload_strap_oe_n_o,
  output logic      [1:0]  upstream_port_o,
  output logic             upstream_strap_error_o,
  output logic      [2:0]  max_payload_cap_o,
  output logic             eeprom_enabled_o,
  output logic             init_done_o,
  output logic             eeprom_serial_clock_o,
  output logic             eeprom_serial_clock_oe_n_o,
  input  wire logic        eeprom_select_n_i,
  output logic             eeprom_select_n_o,
  output logic             eeprom_select_n_oe_n_o,
  output logic             eeprom_serial_out_o,
  input  wire logic        eeprom_serial_in_i,
  output logic      [15:0] eeprom_word_o,
  output logic      [7:0]  eeprom_word_addr_o,
  output logic             eeprom_word_valid_o,
  input  wire logic        smbus_clock_i,
  output logic             smbus_clock_o,
  output logic             smbus_clock_oe_n_o,
  input  wire logic        smbus_data_i,
  output logic             smbus_data_o,
  output logic             smbus_data_oe_n_o,
  input  wire logic [2:0]  smbus_addr_pins_i,
  output logic      [7:0]  smbus_write_data_o,
  output logic             smbus_write_valid_o
);

  sac_pkg::sac_state_t r_reg;
  sac_pkg::sac_state_t r_next;
  logic [`SAC_SYNC_W-1:0] pins;
  logic [`SAC_SYNC_W-1:0] agree;
  logic                   tick;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_c;
  logic                   stop_c;
  logic [7:0]             status;

  function automatic logic [1:0] port_of(input logic [1:0] code);
    unique case (code)
      `SAC_UPS_CODE_P0: port_of = `SAC_PORT0;
      `SAC_UPS_CODE_P1: port_of = `SAC_PORT1;
      `SAC_UPS_CODE_P2: port_of = `SAC_PORT2;
      // Reserved code: fall back to port 0 and flag it
      default:          port_of = `SAC_PORT0;
    endcase
  endfunction

  assign pins = {system_reset_n_i, smbus_addr_pins_i, refclk_request_n_i, smbus_clock_i, smbus_data_i,
                 eeprom_serial_in_i, eeprom_select_n_i, upstream_port_select_i, large_payload_strap_i};
  assign status = {r_reg.pl, r_reg.port, r_reg.ee_en, r_reg.ups_err, 3'h0};

  always_comb begin
    r_next = r_reg;
    r_next.s1 = pins;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    // A pin change counts only once the second and third stages agree
    agree = ~(r_reg.s2 ^ r_reg.s3);
    r_next.filt = (r_reg.filt & ~agree) | (r_reg.s3 & agree);
    r_next.word_vld = 1'b0;
    r_next.wvld = 1'b0;
    r_next.refclk_en = ~r_reg.filt[`SAC_IN_REQ_HI:`SAC_IN_REQ_LO] & ~refclk_disable_i;
    tick = (r_reg.div == '0);
    r_next.div = tick ? `SAC_EE_DIV_W'(`SAC_EE_HALF_CYC - 1) : r_reg.div - 1'b1;

    unique case (r_reg.init)
      sac_pkg::INIT_HOLD: begin
        r_next.cs_n = 1'b1;
        r_next.sck = 1'b0;
        r_next.ee_drv = 1'b0;
        if (r_reg.filt[`SAC_IN_RST]) begin
          r_next.init = sac_pkg::INIT_STRAP;
        end
      end
      sac_pkg::INIT_STRAP: begin
        // Sampled exactly once after release; later pin activity is ignored
        r_next.port = port_of(r_reg.filt[`SAC_IN_UPS_HI:`SAC_IN_UPS_LO]);
        r_next.ups_err = (r_reg.filt[`SAC_IN_UPS_HI:`SAC_IN_UPS_LO] == 2'h2);
        r_next.pl = r_reg.filt[`SAC_IN_PL];
        r_next.ee_en = r_reg.filt[`SAC_IN_CS];
        r_next.ee_drv = r_reg.filt[`SAC_IN_CS];
        r_next.smb_lo = r_reg.filt[`SAC_IN_ADR_HI:`SAC_IN_ADR_LO];
        r_next.addr = 8'h00;
        r_next.init = r_reg.filt[`SAC_IN_CS] ? sac_pkg::INIT_EE_GAP : sac_pkg::INIT_DONE;
      end
      sac_pkg::INIT_EE_GAP: begin
        if (tick) begin
          if (r_reg.addr == `SAC_EE_WORDS) begin
            r_next.init = sac_pkg::INIT_DONE;
          end else begin
            r_next.cs_n = 1'b0;
            r_next.sr = {`SAC_EE_READ_CMD, r_reg.addr, 16'h0000};
            r_next.mosi = 1'(`SAC_EE_READ_CMD >> 7);
            r_next.bcnt = 6'h00;
            r_next.init = sac_pkg::INIT_EE_SHIFT;
          end
        end
      end
      sac_pkg::INIT_EE_SHIFT: begin
        if (tick) begin
          if (!r_reg.sck) begin
            // Rising edge: the EEPROM's reply enters at the bottom
            r_next.sck = 1'b1;
            r_next.sr = {r_reg.sr[30:0], r_reg.filt[`SAC_IN_EEPROM_SERIAL_IN]};
            r_next.bcnt = r_reg.bcnt + 1'b1;
          end else begin
            r_next.sck = 1'b0;
            if (r_reg.bcnt == `SAC_EE_FRAME_BITS) begin
              r_next.word = r_reg.sr[15:0];
              r_next.word_addr = r_reg.addr;
              r_next.word_vld = 1'b1;
              r_next.cs_n = 1'b1;
              r_next.addr = r_reg.addr + 1'b1;
              r_next.init = sac_pkg::INIT_EE_GAP;
            end else begin
              // Change data on the falling edge so it is stable at the next rise
              r_next.mosi = r_reg.sr[31];
            end
          end
        end
      end
      sac_pkg::INIT_DONE: begin
        r_next.cs_n = 1'b1;
      end
      default: begin
        r_next.init = sac_pkg::INIT_HOLD;
      end
    endcase

    // SMBus slave, open-drain, clock never stretched
    scl_rise = r_next.filt[`SAC_IN_SCL] & ~r_reg.filt[`SAC_IN_SCL];
    scl_fall = ~r_next.filt[`SAC_IN_SCL] & r_reg.filt[`SAC_IN_SCL];
    start_c = r_reg.filt[`SAC_IN_SCL] & r_next.filt[`SAC_IN_SCL] & r_reg.filt[`SAC_IN_SDA]
              & ~r_next.filt[`SAC_IN_SDA];
    stop_c = r_reg.filt[`SAC_IN_SCL] & r_next.filt[`SAC_IN_SCL] & ~r_reg.filt[`SAC_IN_SDA]
             & r_next.filt[`SAC_IN_SDA];
    if (r_reg.init != sac_pkg::INIT_DONE || stop_c) begin
      r_next.i2c = sac_pkg::I2C_IDLE;
      r_next.sda_low = 1'b0;
    end else if (start_c) begin
      r_next.i2c = sac_pkg::I2C_RX;
      r_next.ibit = 4'h0;
      r_next.iaddr = 1'b1;
      r_next.sda_low = 1'b0;
    end else begin
      unique case (r_reg.i2c)
        sac_pkg::I2C_IDLE: begin
        end
        sac_pkg::I2C_RX: begin
          if (scl_rise) begin
            r_next.ish = {r_reg.ish[6:0], r_next.filt[`SAC_IN_SDA]};
            r_next.ibit = r_reg.ibit + 1'b1;
          end else if (scl_fall && r_reg.ibit == 4'h8) begin
            if (!r_reg.iaddr) begin
              r_next.wdata = r_reg.ish;
              r_next.wvld = 1'b1;
              r_next.sda_low = 1'b1;
              r_next.i2c = sac_pkg::I2C_RXACK;
            end else if (r_reg.ish[7:1] == {`SAC_SMB_ADDR_HI, r_reg.smb_lo[2:0]}) begin
              r_next.irw = r_reg.ish[0];
              r_next.sda_low = 1'b1;
              r_next.i2c = sac_pkg::I2C_RXACK;
            end else begin
              r_next.i2c = sac_pkg::I2C_IDLE;
            end
          end
        end
        sac_pkg::I2C_RXACK: begin
          if (scl_fall) begin
            r_next.ibit = 4'h0;
            r_next.iaddr = 1'b0;
            if (r_reg.iaddr && r_reg.irw) begin
              r_next.ish = status;
              r_next.sda_low = ~status[7];
              r_next.i2c = sac_pkg::I2C_TX;
            end else begin
              r_next.sda_low = 1'b0;
              r_next.i2c = sac_pkg::I2C_RX;
            end
          end
        end
        sac_pkg::I2C_TX: begin
          if (scl_fall) begin
            if (r_reg.ibit == 4'h7) begin
              r_next.sda_low = 1'b0;
              r_next.i2c = sac_pkg::I2C_TXACK;
            end else begin
              r_next.ish = {r_reg.ish[6:0], 1'b0};
              r_next.sda_low = ~r_reg.ish[6];
              r_next.ibit = r_reg.ibit + 1'b1;
            end
          end
        end
        sac_pkg::I2C_TXACK: begin
          if (scl_rise) begin
            r_next.inack = r_next.filt[`SAC_IN_SDA];
          end else if (scl_fall) begin
            r_next.ibit = 4'h0;
            r_next.ish = status;
            r_next.sda_low = ~r_reg.inack & ~status[7];
            r_next.i2c = r_reg.inack ? sac_pkg::I2C_IDLE : sac_pkg::I2C_TX;
          end
        end
        default: begin
          r_next.i2c = sac_pkg::I2C_IDLE;
        end
      endcase
    end

    // System reset pin restarts the whole start-up sequence
    if (!r_reg.filt[`SAC_IN_RST]) begin
      r_next.init = sac_pkg::INIT_HOLD;
      r_next.cs_n = 1'b1;
      r_next.sck = 1'b0;
      r_next.mosi = 1'b0;
      r_next.ee_drv = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r_reg <= '0;
      r_reg.init <= sac_pkg::INIT_HOLD;
      r_reg.i2c <= sac_pkg::I2C_IDLE;
      r_reg.filt <= `SAC_SYNC_RESET;
      r_reg.cs_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign refclk_enable_o = r_reg.refclk_en;
  assign upstream_port_o = r_reg.port;
  assign upstream_strap_error_o = r_reg.ups_err;
  assign max_payload_cap_o = r_reg.pl ? `SAC_MPS_512 : `SAC_MPS_256;
  assign eeprom_enabled_o = r_reg.ee_en;
  assign init_done_o = (r_reg.init == sac_pkg::INIT_DONE);
  // Pins stay released until the straps are captured, so board levels are read
  assign eeprom_serial_clock_o = r_reg.sck;
  assign eeprom_serial_clock_oe_n_o = ~r_reg.ee_drv;
  assign eeprom_select_n_o = r_reg.cs_n;
  assign eeprom_select_n_oe_n_o = ~r_reg.ee_drv;
  assign eeprom_serial_out_o = r_reg.mosi;
  assign eeprom_word_o = r_reg.word;
  assign eeprom_word_addr_o = r_reg.word_addr;
  assign eeprom_word_valid_o = r_reg.word_vld;
  assign smbus_clock_o = 1'b0;
  assign smbus_clock_oe_n_o = 1'b1;
  assign smbus_data_o = 1'b0;
  assign smbus_data_oe_n_o = ~r_reg.sda_low;
  assign smbus_write_data_o = r_reg.wdata;
  assign smbus_write_valid_o = r_reg.wvld;
  // Strap pins turn into debug outputs only once start-up is over
  assign large_payload_strap_o = (r_reg.i2c != sac_pkg::I2C_IDLE);
  assign large_payload_strap_oe_n_o = ~init_done_o;
  assign upstream_port_select_o = r_reg.irw;
  assign upstream_port_select_oe_n_o = ~init_done_o;

endmodule

// ==== sac_eeprom_model.sv ====
// Behavioural serial EEPROM answering read frames from the loader
`timescale 1ns/1ns
`include "sac_regs.svh"
module sac_eeprom_model (
  input  wire logic sck_i,
  input  wire logic cs_n_i,
  input  wire logic mosi_i,
  input  wire logic slow_i,
  output logic      miso_o
);
  logic [15:0] in_reg;
  logic [15:0] out_reg;
  logic [5:0]  cnt_reg;
  initial miso_o = 1'b0;
  // No pull on this line, so a deselected part shows a moving level
  always #20 if (cs_n_i) miso_o = ~miso_o;
  always @(negedge cs_n_i) cnt_reg = 6'h00;
  always @(posedge sck_i) begin
    if (!cs_n_i) begin
      in_reg = {in_reg[14:0], mosi_i};
      cnt_reg = cnt_reg + 6'h01;
    end
  end
  // Word is derived from the address so the bench can predict it
  always @(negedge sck_i) begin
    if (!cs_n_i && cnt_reg >= 6'h10) begin
      // Anything but the read command answers all ones, so a bad command shows up as a wrong word
      out_reg = (cnt_reg != 6'h10) ? {out_reg[14:0], 1'b0} : (in_reg[15:8] == `SAC_EE_READ_CMD) ?
        {in_reg[7:0] ^ 8'h5A, ~in_reg[7:0]} : 16'hFFFF;
      #(slow_i ? 300 : 5);
      miso_o = out_reg[15];
    end
  end
endmodule

// ==== sac_config_chk.sv ====
// Port assertions for the strap and serial configuration loader
`timescale 1ns/1ns
module sac_config_chk (
  input wire logic       core_clk_i,
  input wire logic       resetn_i,
  input wire logic [3:1] refclk_request_n_i,
  input wire logic [3:1] refclk_disable_i,
  input wire logic [3:1] refclk_enable_o,
  input wire logic [1:0] upstream_port_select_i,
  input wire logic       large_payload_strap_i,
  input wire logic       large_payload_strap_oe_n_o,
  input wire logic       upstream_port_select_oe_n_o,
  input wire logic [1:0] upstream_port_o,
  input wire logic       upstream_strap_error_o,
  input wire logic [2:0] max_payload_cap_o,
  input wire logic       eeprom_enabled_o,
  input wire logic       init_done_o,
  input wire logic       eeprom_serial_clock_o,
  input wire logic       eeprom_serial_clock_oe_n_o,
  input wire logic       eeprom_select_n_o,
  input wire logic       eeprom_select_n_oe_n_o,
  input wire logic       eeprom_word_valid_o,
  input wire logic       smbus_data_oe_n_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  ref_req_a: assert property (($stable(refclk_request_n_i) && $stable(refclk_disable_i))[*7] |->
    refclk_enable_o == ~(refclk_request_n_i | refclk_disable_i)) else $error("refclk enable off request");
  ref_dis_a: assert property (|refclk_disable_i |=> (refclk_enable_o & $past(refclk_disable_i)) == 3'h0)
    else $error("disabled refclk still on");
  // Pins are compared only in bypass, where init ends while the board still holds them
  ups_map_a: assert property ($rose(init_done_o) && !eeprom_enabled_o |->
    upstream_port_o == (upstream_port_select_i == 2'h3 ? 2'h2 : {1'b0, upstream_port_select_i == 2'h1})
    && upstream_strap_error_o == (upstream_port_select_i == 2'h2)) else $error("upstream port off strap");
  mps_map_a: assert property ($rose(init_done_o) && !eeprom_enabled_o |->
    max_payload_cap_o == (large_payload_strap_i ? 3'h2 : 3'h1)) else $error("payload cap off strap");
  ee_bypass_a: assert property (!eeprom_enabled_o |-> eeprom_select_n_oe_n_o && eeprom_serial_clock_oe_n_o)
    else $error("eeprom pins driven in bypass");
  cs_frame_a: assert property ($fell(eeprom_select_n_o) |-> !eeprom_serial_clock_o[*8] ##[16:20] eeprom_serial_clock_o)
    else $error("frame start timing wrong");
  sck_cs_a: assert property (eeprom_serial_clock_o |-> !eeprom_select_n_o)
    else $error("serial clock outside frame");
  sck_high_a: assert property ($rose(eeprom_serial_clock_o) |-> eeprom_serial_clock_o[*8])
    else $error("serial clock high phase short");
  word_end_a: assert property ($rose(eeprom_select_n_o) |-> eeprom_word_valid_o ##1 !eeprom_word_valid_o)
    else $error("word valid not at frame end");
  dbg_oe_a: assert property (!init_done_o |-> large_payload_strap_oe_n_o && upstream_port_select_oe_n_o)
    else $error("debug pin driven during init");
  sda_init_a: assert property (!smbus_data_oe_n_o |-> init_done_o)
    else $error("smbus data driven before init");
  cover property ($rose(init_done_o) && eeprom_enabled_o);
  cover property (eeprom_word_valid_o);
  cover property ($rose(init_done_o) && upstream_port_o == 2'h2);
  cover property (!smbus_data_oe_n_o);
endmodule
bind sac_config sac_config_chk i_sac_config_chk (
  .core_clk_i, .resetn_i, .refclk_request_n_i, .refclk_disable_i, .refclk_enable_o, .upstream_port_select_i,
  .large_payload_strap_i, .large_payload_strap_oe_n_o, .upstream_port_select_oe_n_o, .upstream_port_o,
  .upstream_strap_error_o, .max_payload_cap_o, .eeprom_enabled_o, .init_done_o, .eeprom_serial_clock_o,
  .eeprom_serial_clock_oe_n_o, .eeprom_select_n_o, .eeprom_select_n_oe_n_o, .eeprom_word_valid_o, .smbus_data_oe_n_o
);

// ==== testbench.sv ====
// Self-checking bench for the strap and serial configuration loader
`timescale 1ns/1ns
`include "sac_regs.svh"
`define CHK(n, e, g) check(n, 24'(e), 24'(g))
module testbench;
  logic        core_clk_i, resetn_i, system_reset_n_i, large_payload_strap_i, eeprom_select_n_i, eeprom_serial_in_i;
  logic        smbus_clock_i, smbus_data_i, init_done_o, eeprom_enabled_o, upstream_strap_error_o, eeprom_word_valid_o;
  logic        eeprom_serial_clock_o, eeprom_serial_clock_oe_n_o, eeprom_select_n_o, eeprom_select_n_oe_n_o;
  logic        eeprom_serial_out_o, smbus_clock_o, smbus_clock_oe_n_o, smbus_data_o, smbus_data_oe_n_o;
  logic        smbus_write_valid_o, large_payload_strap_oe_n_o, cs_strap, slow, scl_h, sda_h, done_q;
  logic        dbg_pl, dbg_ups, dbg_ups_oe_n, rb;
  logic [3:1]  refclk_request_n_i, refclk_disable_i, refclk_enable_o;
  logic [1:0]  upstream_port_select_i, upstream_port_o;
  logic [2:0]  max_payload_cap_o, smbus_addr_pins_i;
  logic [15:0] eeprom_word_o;
  logic [7:0]  eeprom_word_addr_o, smbus_write_data_o, wd, rd;
  // The reserved upstream code is never strapped
  logic [1:0]  ups_tab [4] = '{2'h0, 2'h1, 2'h3, 2'h1};
  logic [6:0]  exp_s;
  logic [23:0] eq[$];
  logic [7:0]  sq[$];
  logic [6:0]  pq[$];
  int          error_cnt;
  int          num_checks;

  sac_config i_sac_config (
    .core_clk_i, .resetn_i, .system_reset_n_i, .refclk_request_n_i, .refclk_disable_i, .refclk_enable_o,
    .upstream_port_select_i, .upstream_port_select_o(dbg_ups), .upstream_port_select_oe_n_o(dbg_ups_oe_n),
    .large_payload_strap_i, .large_payload_strap_o(dbg_pl), .large_payload_strap_oe_n_o, .upstream_port_o,
    .upstream_strap_error_o,
    .max_payload_cap_o, .eeprom_enabled_o, .init_done_o, .eeprom_serial_clock_o, .eeprom_serial_clock_oe_n_o,
    .eeprom_select_n_i, .eeprom_select_n_o, .eeprom_select_n_oe_n_o, .eeprom_serial_out_o, .eeprom_serial_in_i,
    .eeprom_word_o, .eeprom_word_addr_o, .eeprom_word_valid_o, .smbus_clock_i, .smbus_clock_o, .smbus_clock_oe_n_o,
    .smbus_data_i, .smbus_data_o, .smbus_data_oe_n_o, .smbus_addr_pins_i, .smbus_write_data_o, .smbus_write_valid_o
  );
  sac_eeprom_model i_sac_eeprom_model (
    .sck_i(eeprom_serial_clock_o & !eeprom_serial_clock_oe_n_o), .cs_n_i(eeprom_select_n_i),
    .mosi_i(eeprom_serial_out_o), .slow_i(slow), .miso_o(eeprom_serial_in_i)
  );
  // Shared pins resolve from every party's drive; the bus lines have pull-ups
  assign eeprom_select_n_i = eeprom_select_n_oe_n_o ? cs_strap : eeprom_select_n_o;
  assign smbus_clock_i = scl_h & (smbus_clock_oe_n_o | smbus_clock_o);
  assign smbus_data_i = sda_h & (smbus_data_oe_n_o | smbus_data_o);

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic check(input string n, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask
  // Data moves only while the clock is low, so no false start or stop is seen
  task automatic i2c_bit(input logic b, output logic r);
    tick(2);
    sda_h = b;
    tick(2);
    scl_h = 1'b1;
    tick(4);
    r = smbus_data_i;
    scl_h = 1'b0;
  endtask
  task automatic i2c_byte(input logic [7:0] d, input logic exp_ack);
    logic r;
    for (int i = 7; i >= 0; i--) i2c_bit(d[i], r);
    i2c_bit(1'b1, r);
    `CHK("smbus ack", exp_ack, r);
  endtask
  task automatic i2c_cond(input logic stop);
    tick(4);
    sda_h = !stop;
    tick(4);
    scl_h = 1'b1;
    tick(8);
    sda_h = stop;
    tick(8);
    scl_h = stop;
  endtask

  always @(posedge core_clk_i) begin
    done_q <= init_done_o;
    if (init_done_o && !done_q)
      `CHK("straps", pq.pop_front(), {upstream_port_o, upstream_strap_error_o, max_payload_cap_o, eeprom_enabled_o});
    if (eeprom_word_valid_o) `CHK("eeprom word", eq.pop_front(), {eeprom_word_addr_o, eeprom_word_o});
    if (smbus_write_valid_o) `CHK("smbus data", sq.pop_front(), smbus_write_data_o);
  end

  initial begin
    {resetn_i, system_reset_n_i, cs_strap, slow, large_payload_strap_i, scl_h, sda_h} = 7'h03;
    {refclk_request_n_i, refclk_disable_i, upstream_port_select_i, smbus_addr_pins_i} = 11'h700;
    wd = 8'($urandom(32'h4f76_3d82));
    tick(3);
    resetn_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      system_reset_n_i = 1'b0;
      upstream_port_select_i = ups_tab[i % 4];
      large_payload_strap_i = 1'($urandom);
      smbus_addr_pins_i = 3'($urandom);
      cs_strap = (i > 3);
      slow = (i == 5);
      exp_s = {upstream_port_select_i == `SAC_UPS_CODE_P2 ? `SAC_PORT2 : upstream_port_select_i == `SAC_UPS_CODE_P1 ?
        `SAC_PORT1 : `SAC_PORT0, upstream_port_select_i == 2'h2, large_payload_strap_i ? `SAC_MPS_512 : `SAC_MPS_256,
        cs_strap};
      pq.push_back(exp_s);
      if (cs_strap) for (int a = 0; a < 4; a++) eq.push_back({8'(a), 8'(a) ^ 8'h5A, ~8'(a)});
      tick(6);
      system_reset_n_i = 1'b1;
      tick(12);
      upstream_port_select_i = ups_tab[(i + 1) % 4];
      large_payload_strap_i = ~large_payload_strap_i;
      for (int t = 0; t < 9000 && init_done_o !== 1'b1; t++) tick(1);
      `CHK("strap hold", exp_s, {upstream_port_o, upstream_strap_error_o, max_payload_cap_o, eeprom_enabled_o});
      `CHK("debug drive", 2'h0, {large_payload_strap_oe_n_o, dbg_ups_oe_n});
      refclk_request_n_i = 3'($urandom);
      refclk_disable_i = 3'($urandom);
      tick(8);
      `CHK("refclk", 3'(~(refclk_request_n_i | refclk_disable_i)), refclk_enable_o);
    end
    i2c_cond(1'b0);
    i2c_byte({`SAC_SMB_ADDR_HI, ~smbus_addr_pins_i, 1'b0}, 1'b1);
    i2c_cond(1'b1);
    wd = 8'($urandom);
    sq.push_back(wd);
    i2c_cond(1'b0);
    i2c_byte({`SAC_SMB_ADDR_HI, smbus_addr_pins_i, 1'b0}, 1'b0);
    i2c_byte(wd, 1'b0);
    `CHK("debug write", 2'h2, {dbg_pl, dbg_ups});
    i2c_cond(1'b1);
    i2c_cond(1'b0);
    i2c_byte({`SAC_SMB_ADDR_HI, smbus_addr_pins_i, 1'b1}, 1'b0);
    for (int i = 7; i >= 0; i--) i2c_bit(1'b1, rd[i]);
    `CHK("debug read", 2'h3, {dbg_pl, dbg_ups});
    i2c_bit(1'b1, rb);
    i2c_cond(1'b1);
    `CHK("smbus status", {exp_s[3:1] == `SAC_MPS_512, exp_s[6:5], exp_s[0], exp_s[4], 3'h0}, rd);
    `CHK("debug idle", 1'b0, dbg_pl);
    `CHK("smbus clock", 3'h4, {smbus_clock_oe_n_o, smbus_clock_o, smbus_data_o});
    `CHK("queues drained", 0, eq.size() + sq.size() + pq.size());
    finish_test;
  end

  initial begin
    #1_000_000;
    error_cnt++;
    finish_test;
  end
endmodule
